// [hw/ttr_router.sv]
// trigger and timebase router with an AXI4-Lite register slave
`timescale 1ns/1ns

// Overview of operation
// - seven two-way shared trigger lines each either drive a chosen internal signal or receive.
// - on the backplane build, shared lines zero to five map one to one onto backplane lines.
// - on the backplane build, shared line six is the star trigger line, used for receiving.
// - the timebase is sent or taken only on the dedicated shared clock line, never elsewhere.
// - the primary source is the internal base clock or the shared clock line timebase.
// - with the internal timebase chosen, the block may drive the register clock aclk, halved, onto the shared clock line.
// - after reset the internal timebase is used and the clock line driver is off.
// - the master's register clock aclk, halved, times the slaves, which take it from the clock line; the master itself runs on the internal base clock.
// - the trigger source is any function pin or any of shared trigger lines zero to six.
// - the trigger fires on a chosen rising or falling edge of the selected source.
// - each function pin has its own edge or level detection and its own polarity.
module ttr_router import ttr_pkg::*; (
  // register bus clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi write address
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi read address
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // primary timebase domain
  input wire logic base_clk,
  input wire logic [NUM_ROUTES-1:0] internal_sigs,
  output logic trig_pulse,
  output logic [NUM_FUNC-1:0] func_cond,
  // timebase selection for the clock mux
  output logic use_bus_timebase,
  // function pins
  input wire logic [NUM_FUNC-1:0] function_pin_in,
  // shared trigger lines
  input wire logic [NUM_LINES-1:0] shared_trigger_lines_in,
  output logic [NUM_LINES-1:0] shared_trigger_lines_out,
  output logic [NUM_LINES-1:0] shared_trigger_lines_oe,
  // shared clock line
  input wire logic shared_clock_line_in,
  output logic shared_clock_line_out,
  output logic shared_clock_line_oe
);

  // ----------------------------------------------------------------
  // register bus slave
  // ----------------------------------------------------------------
  logic [31:0] ctrl_r, line_r, func_r;
  logic [AXI_AW-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic aw_got_r, w_got_r;
  logic wr_fire;
  logic [31:0] stat_word;
  ttr_ctrl_t ctrl_v;

  assign ctrl_v = ttr_ctrl_t'(ctrl_r);
  assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res & mask;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      aw_got_r <= 1'b0;
      awaddr_r <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_got_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_got_r <= 1'b0;
    end else if (!aw_got_r && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
      w_got_r <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_got_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_got_r <= 1'b0;
    end else if (!w_got_r && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  // register writes and the write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= CTRL_RST;
      line_r <= LINE_RST;
      func_r <= FUNC_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= RESP_OKAY;
      case (awaddr_r)
        REG_CTRL: ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r, CTRL_MASK);
        REG_LINE: line_r <= merge(line_r, wdata_r, wstrb_r, LINE_MASK);
        REG_FUNC: func_r <= merge(func_r, wdata_r, wstrb_r, FUNC_MASK);
        REG_STAT: s_axi_bresp <= RESP_OKAY;
        default: s_axi_bresp <= RESP_SLVERR;
      endcase
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // reads; a new address is taken only once the previous data has gone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case (s_axi_araddr)
        REG_CTRL: s_axi_rdata <= ctrl_r;
        REG_LINE: s_axi_rdata <= line_r;
        REG_FUNC: s_axi_rdata <= func_r;
        REG_STAT: s_axi_rdata <= stat_word;
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // timebase selection and clock line drive
  // ----------------------------------------------------------------
  logic clk_div_r;
  logic drive_clk_ok;

  // only the internal timebase may go out, and only on the clock line
  assign drive_clk_ok = ctrl_v.drive_clk && !ctrl_v.use_bus_clk;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      use_bus_timebase <= 1'b0;
      shared_clock_line_oe <= 1'b0;
      shared_clock_line_out <= 1'b0;
      clk_div_r <= 1'b0;
    end else begin
      use_bus_timebase <= ctrl_v.use_bus_clk;
      shared_clock_line_oe <= drive_clk_ok;
      // outputs must leave a flop, so the register clock aclk goes out halved
      clk_div_r <= drive_clk_ok ? !clk_div_r : 1'b0;
      shared_clock_line_out <= clk_div_r;
    end
  end

  // ----------------------------------------------------------------
  // status side: line levels, clock line activity, trigger count
  // ----------------------------------------------------------------
  logic [NUM_LINES-1:0] lines_a;
  logic clk_in_a, clk_in_d_r, clk_seen;
  logic [ACT_W-1:0] act_cnt_r;
  logic [CNT_W-1:0] cnt_gray_l, cnt_gray_a, cnt_bin_a;

  ttr_sync2 #(.W(NUM_LINES + 1)) u_sync_stat (
    .clk(aclk),
    .rst_n(aresetn),
    .d({shared_clock_line_in, shared_trigger_lines_in}),
    .q({clk_in_a, lines_a})
  );

  ttr_sync2 #(.W(CNT_W)) u_sync_cnt (
    .clk(aclk),
    .rst_n(aresetn),
    .d(cnt_gray_l),
    .q(cnt_gray_a)
  );

  // a slave needs a live clock line before selecting it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_in_d_r <= 1'b0;
      act_cnt_r <= '1;
    end else begin
      clk_in_d_r <= clk_in_a;
      if (clk_in_a != clk_in_d_r) begin
        act_cnt_r <= '0;
      end else if (act_cnt_r != '1) begin
        act_cnt_r <= act_cnt_r + 1'b1;
      end
    end
  end

  assign clk_seen = (act_cnt_r != '1);

  // each binary bit is the parity of the gray bits at and above it
  always_comb begin
    for (int i = 0; i < CNT_W; i++) begin
      cnt_bin_a[i] = ^(cnt_gray_a >> i);
    end
  end

  assign stat_word = {cnt_bin_a, 5'h00, clk_seen, shared_clock_line_oe, use_bus_timebase,
                      1'b0, lines_a};

  // ----------------------------------------------------------------
  // primary timebase domain
  // ----------------------------------------------------------------
  logic link_rstn;
  ttr_cfg_t cfg_a, cfg_l, cfg_hold_r;
  logic xfer_tgl_r, xfer_ack_a, req_l, req_seen_r;
  logic [NUM_SRC-1:0] src_l;
  logic src_bit, src_prev_r;
  logic [CNT_W-1:0] cnt_bin_r;
  logic [NUM_FUNC-1:0] fn_lvl, fn_prev_r;

  assign cfg_a = {ctrl_r, line_r[NUM_LINES*(ROUTE_W+1)-1:0], func_r};

  ttr_sync2 #(.W(1)) u_sync_rst (
    .clk(base_clk),
    .rst_n(1'b1),
    .d(aresetn),
    .q(link_rstn)
  );

  // a held copy crosses on a toggle handshake, so all its bits land on one edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_hold_r <= {CTRL_RST, LINE_RST[NUM_LINES*(ROUTE_W+1)-1:0], FUNC_RST};
      xfer_tgl_r <= 1'b0;
    end else if (xfer_tgl_r == xfer_ack_a && cfg_hold_r != cfg_a) begin
      cfg_hold_r <= cfg_a;
      xfer_tgl_r <= !xfer_tgl_r;
    end
  end

  ttr_sync2 #(.W(1)) u_sync_req (.clk(base_clk), .rst_n(link_rstn), .d(xfer_tgl_r), .q(req_l));
  ttr_sync2 #(.W(1)) u_sync_ack (.clk(aclk), .rst_n(aresetn), .d(req_seen_r), .q(xfer_ack_a));

  // the held copy is stable from the toggle until the acknowledge returns
  always_ff @(posedge base_clk) begin
    if (!link_rstn) begin
      req_seen_r <= 1'b0;
      cfg_l <= {CTRL_RST, LINE_RST[NUM_LINES*(ROUTE_W+1)-1:0], FUNC_RST};
    end else begin
      req_seen_r <= req_l;
      if (req_l != req_seen_r) begin
        cfg_l <= cfg_hold_r;
      end
    end
  end

  // function pins take indices 0..9, shared lines 0..6 follow
  ttr_sync2 #(.W(NUM_SRC)) u_sync_pins (
    .clk(base_clk),
    .rst_n(link_rstn),
    .d({shared_trigger_lines_in, function_pin_in}),
    .q(src_l)
  );

  // out-of-range selections read as a quiet low source
  assign src_bit = (cfg_l.ctrl.trig_src < SRC_W'(NUM_SRC)) ?
                   src_l[cfg_l.ctrl.trig_src] : 1'b0;

  always_ff @(posedge base_clk) begin
    if (!link_rstn) begin
      src_prev_r <= 1'b0;
      trig_pulse <= 1'b0;
    end else begin
      src_prev_r <= src_bit;
      if (cfg_l.ctrl.trig_fall) begin
        trig_pulse <= cfg_l.ctrl.trig_en && src_prev_r && !src_bit;
      end else begin
        trig_pulse <= cfg_l.ctrl.trig_en && !src_prev_r && src_bit;
      end
    end
  end

  // gray count so the status side can read it across domains
  always_ff @(posedge base_clk) begin
    if (!link_rstn) begin
      cnt_bin_r <= '0;
      cnt_gray_l <= '0;
    end else begin
      if (trig_pulse) begin
        cnt_bin_r <= cnt_bin_r + 1'b1;
      end
      cnt_gray_l <= cnt_bin_r ^ (cnt_bin_r >> 1);
    end
  end

  assign fn_lvl = src_l[NUM_FUNC-1:0] ^ cfg_l.func.pol;

  always_ff @(posedge base_clk) begin
    if (!link_rstn) begin
      fn_prev_r <= '0;
      func_cond <= '0;
    end else begin
      fn_prev_r <= fn_lvl;
      func_cond <= (cfg_l.func.edge_mode & fn_lvl & ~fn_prev_r) |
                   (~cfg_l.func.edge_mode & fn_lvl);
    end
  end

  // line n maps to backplane line n for 0..5, line 6 to the star line
  // the star line is normally received; driving it is left to software
  for (genvar i = 0; i < NUM_LINES; i++) begin : g_line
    always_ff @(posedge base_clk) begin
      if (!link_rstn) begin
        shared_trigger_lines_oe[i] <= 1'b0;
        shared_trigger_lines_out[i] <= 1'b0;
      end else begin
        shared_trigger_lines_oe[i] <= cfg_l.line[i].drive;
        shared_trigger_lines_out[i] <= internal_sigs[cfg_l.line[i].route];
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  trig_rise_a: assert property (@(posedge base_clk) disable iff (!link_rstn)
    cfg_l.ctrl.trig_en && !cfg_l.ctrl.trig_fall && src_bit && !src_prev_r |=> trig_pulse)
    else $error("rising edge missed");

  trig_fall_a: assert property (@(posedge base_clk) disable iff (!link_rstn)
    cfg_l.ctrl.trig_en && cfg_l.ctrl.trig_fall && !src_bit && src_prev_r |=> trig_pulse)
    else $error("falling edge missed");

  pulse_single_a: assert property (@(posedge base_clk) disable iff (!link_rstn)
    trig_pulse |-> ##1 !trig_pulse)
    else $error("trigger pulse longer than one cycle");

  pulse_cause_a: assert property (@(posedge base_clk) disable iff (!link_rstn)
    trig_pulse |-> $past(src_bit) != $past(src_prev_r) && $past(cfg_l.ctrl.trig_en))
    else $error("trigger pulse without an edge");

  clk_reset_a: assert property (@(posedge aclk)
    !aresetn |=> !shared_clock_line_oe && !use_bus_timebase)
    else $error("timebase state wrong after reset");

  clk_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
    shared_clock_line_oe |-> !use_bus_timebase ##1 (shared_clock_line_out != $past(
      shared_clock_line_out)) || !shared_clock_line_oe)
    else $error("clock line driven while bus timebase in use");

  base_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 use_bus_timebase == $past(ctrl_v.use_bus_clk))
    else $error("timebase select not following control");

  line_drive_a: assert property (@(posedge base_clk) disable iff (!link_rstn)
    cfg_l.line[0].drive ##1 cfg_l.line[0].drive |-> shared_trigger_lines_oe[0] &&
      shared_trigger_lines_out[0] == $past(internal_sigs[cfg_l.line[0].route]))
    else $error("shared line 0 not driven as configured");

  func_level_a: assert property (@(posedge base_clk) disable iff (!link_rstn)
    !cfg_l.func.edge_mode[0] ##1 !cfg_l.func.edge_mode[0] |->
      func_cond[0] == $past(fn_lvl[0]))
    else $error("level mode pin 0 wrong");

  src_range_a: assert property (@(posedge base_clk) disable iff (!link_rstn)
    cfg_l.ctrl.trig_src >= SRC_W'(NUM_SRC) [*2] |=> !trig_pulse)
    else $error("pulse from an unmapped source");

endmodule

// [hw/ttr_pkg.sv]
// constants, field layouts and carriers for the trigger and timebase router
package ttr_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_LINES = 7;
  localparam int NUM_FUNC = 10;
  localparam int NUM_SRC = NUM_FUNC + NUM_LINES;
  localparam int SRC_W = 5;
  localparam int ROUTE_W = 3;
  localparam int NUM_ROUTES = 8;
  localparam int AXI_AW = 12;
  localparam int CNT_W = 16;
  localparam int ACT_W = 4;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int BASE_CLK_HZ = 20_000_000;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [AXI_AW-1:0] REG_CTRL = 12'h000;
  localparam logic [AXI_AW-1:0] REG_LINE = 12'h004;
  localparam logic [AXI_AW-1:0] REG_FUNC = 12'h008;
  localparam logic [AXI_AW-1:0] REG_STAT = 12'h00C;

  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] LINE_RST = 32'h0000_0000;
  localparam logic [31:0] FUNC_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h0000_01FF;
  localparam logic [31:0] LINE_MASK = 32'h0FFF_FFFF;
  localparam logic [31:0] FUNC_MASK = 32'h03FF_03FF;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // field layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [22:0] rsvd;
    logic [SRC_W-1:0] trig_src;
    logic trig_fall;
    logic trig_en;
    logic drive_clk;
    logic use_bus_clk;
  } ttr_ctrl_t;

  typedef struct packed {
    logic drive;
    logic [ROUTE_W-1:0] route;
  } ttr_line_t;

  typedef struct packed {
    logic [5:0] rsvd_hi;
    logic [NUM_FUNC-1:0] pol;
    logic [5:0] rsvd_lo;
    logic [NUM_FUNC-1:0] edge_mode;
  } ttr_func_t;

  typedef struct packed {
    ttr_ctrl_t ctrl;
    ttr_line_t [NUM_LINES-1:0] line;
    ttr_func_t func;
  } ttr_cfg_t;

endpackage

// [hw/ttr_sync2.sv]
// two-stage synchroniser for levels and gray-coded words
`timescale 1ns/1ns
module ttr_sync2 #(
  parameter int W = 1
) (
  // clock and reset of the receiving domain
  input wire logic clk,
  input wire logic rst_n,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

// [verif/ttr_peer_board.sv]
// behavioural model of another board on the shared trigger bus
`timescale 1ns/1ns
module ttr_peer_board import ttr_pkg::*; (
  // timebase and reset of the peer
  input wire logic clk,
  input wire logic rst_n,
  // role and trigger level set by the bench
  input wire logic is_master,
  input wire logic [2:0] line_sel,
  input wire logic line_lvl,
  // shared bus side
  output logic [NUM_LINES-1:0] lines_out,
  output logic [NUM_LINES-1:0] lines_oe,
  output logic clk_line_out,
  output logic clk_line_oe
);
  // ------------------------------------------------------------
  // master drives timebase and one free line, slave stays off
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n || !is_master) begin
      clk_line_oe <= 1'b0;
      clk_line_out <= 1'b0;
      lines_oe <= '0;
      lines_out <= '0;
    end else begin
      clk_line_oe <= 1'b1;
      clk_line_out <= ~clk_line_out;
      lines_oe <= NUM_LINES'(1) << line_sel;
      lines_out <= {NUM_LINES{line_lvl}};
    end
  end
endmodule

// [verif/tb_trigger_timebase_router.sv]
// self-checking bench for the trigger and timebase router
`timescale 1ns/1ns
module tb_trigger_timebase_router import ttr_pkg::*;;
  logic aclk, aresetn, base_clk;
  logic [AXI_AW-1:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, lcfg;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [NUM_ROUTES-1:0] isig;
  logic [NUM_FUNC-1:0] fcond, fpin, pol;
  logic [NUM_LINES-1:0] tl_in, tl_out, tl_oe, p_out, p_oe;
  logic [NUM_LINES-1:0] flt_r = '0;
  logic trig_pulse, use_bus, cl_in, cl_out, cl_oe, p_cl, p_cl_oe, p_master, p_lvl, fall, tmp;
  logic cl_flt = 1'b0;
  logic prev_tp = 1'b0;
  logic [2:0] p_sel;
  int n_errors, n_tests, n_pulse, n_fc, src, base, exp_n;
  integer seed = 32'h4B59;
  logic [33:0] rd_q[$];
  logic [33:0] rm_q[$];
  logic [1:0] b_q[$];

  // ------------------------------------------------------------
  // clocks, wires, design and peer
  // ------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  initial begin
    base_clk = 1'b0;
    #4;
    forever #6 base_clk = ~base_clk;
  end
  // a released line settles at the inverse of its last driven level
  always @(posedge base_clk) flt_r <= ((tl_oe | p_oe) & ~tl_in) | (~(tl_oe | p_oe) & flt_r);
  always @(posedge base_clk) cl_flt <= (cl_oe | p_cl_oe) ? ~cl_in : cl_flt;
  assign tl_in = (tl_oe & tl_out) | (~tl_oe & p_oe & p_out) | (~tl_oe & ~p_oe & flt_r);
  assign cl_in = cl_oe ? cl_out : (p_cl_oe ? p_cl : cl_flt);

  ttr_router dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .base_clk(base_clk), .internal_sigs(isig), .trig_pulse(trig_pulse), .func_cond(fcond),
    .use_bus_timebase(use_bus), .function_pin_in(fpin), .shared_trigger_lines_in(tl_in),
    .shared_trigger_lines_out(tl_out), .shared_trigger_lines_oe(tl_oe),
    .shared_clock_line_in(cl_in), .shared_clock_line_out(cl_out), .shared_clock_line_oe(cl_oe)
  );
  ttr_peer_board peer_u (
    .clk(base_clk), .rst_n(aresetn), .is_master(p_master), .line_sel(p_sel), .line_lvl(p_lvl),
    .lines_out(p_out), .lines_oe(p_oe), .clk_line_out(p_cl), .clk_line_oe(p_cl_oe)
  );

  // ------------------------------------------------------------
  // checking, bus tasks and watchers
  // ------------------------------------------------------------
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] r);
    b_q.push_back(r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (!awready);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (!wready);
        wvalid <= 1'b0;
      end
    join
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic [1:0] r);
    rd_q.push_back({r, e & m});
    rm_q.push_back({2'h3, m});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
  endtask
  task automatic drv_src(input int s, input logic lvl);
    @(posedge aclk);
    if (s < NUM_FUNC) fpin[s] <= lvl;
    else p_lvl <= lvl;
    cyc(2);
  endtask

  always @(posedge aclk) begin
    if (bvalid && bready) chk(34'(bresp), 34'(b_q.pop_front()));
    if (rvalid && rready) chk({rresp, rdata} & rm_q.pop_front(), rd_q.pop_front());
  end
  always @(posedge base_clk) begin
    prev_tp <= trig_pulse;
    if (fcond != '0) n_fc++;
    if (trig_pulse) begin
      n_pulse++;
      chk(34'(prev_tp), 34'(0));
    end
  end
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    end_sim();
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    aresetn = 1'b0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = '0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    isig = '0;
    fpin = '0;
    p_master = 1'b0;
    p_sel = '0;
    p_lvl = 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(4);
    chk(34'({use_bus, cl_oe}), 34'(0));
    rd(REG_CTRL, CTRL_RST, '1, RESP_OKAY);
    rd(REG_LINE, LINE_RST, '1, RESP_OKAY);
    rd(REG_FUNC, FUNC_RST, '1, RESP_OKAY);
    wr(12'h010, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
    rd(12'h010, 32'h0, '1, RESP_SLVERR);
    wr(REG_STAT, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
    // rising and falling edges, on a pin and on a peer-driven line
    exp_n = 0;
    for (int k = 0; k < 5; k++) begin
      fall = k[0];
      // the last pass picks a source number that maps to nothing
      if (k == 4) src = 31;
      else if (k[1]) src = NUM_FUNC + ($unsigned($random(seed)) % NUM_LINES);
      else src = $unsigned($random(seed)) % NUM_FUNC;
      p_sel <= 3'(src - NUM_FUNC);
      wr(REG_CTRL, (32'(src) << 4) | (32'(fall) << 3) | 32'h4, 4'hF, RESP_OKAY);
      p_master <= 1'b1;
      cyc(6);
      base = n_pulse;
      drv_src(src, 1'b1);
      drv_src(src, 1'b0);
      drv_src(src, 1'b1);
      cyc(4);
      chk(34'(n_pulse - base), (k == 4) ? 34'(0) : (fall ? 34'(1) : 34'(2)));
      drv_src(src, 1'b0);
      if (k < 4) exp_n += 2;
      cyc(4);
      wr(REG_CTRL, 32'h0, 4'hF, RESP_OKAY);
    end
    rd(REG_STAT, {exp_n[15:0], 16'h0400}, 32'hFFFF_0400, RESP_OKAY);
    p_master <= 1'b0;
    // timebase driven out, then taken from the shared clock line
    wr(REG_CTRL, 32'h2, 4'hF, RESP_OKAY);
    cyc(2);
    chk(34'({cl_oe, tl_oe}), 34'h80);
    tmp = cl_out;
    cyc(1);
    chk(34'(cl_out ^ tmp), 34'(1));
    wr(REG_CTRL, 32'h3, 4'hF, RESP_OKAY);
    cyc(2);
    chk(34'({use_bus, cl_oe}), 34'h2);
    // a quiet clock line must age out of the activity flag
    cyc(18);
    rd(REG_STAT, 32'h100, 32'h700, RESP_OKAY);
    wr(REG_CTRL, 32'h0, 4'hF, RESP_OKAY);
    // per-line drive and routing
    wr(REG_LINE, 32'hFFFF_FFFF, 4'h1, RESP_OKAY);
    rd(REG_LINE, 32'hFF, '1, RESP_OKAY);
    lcfg = $random(seed) & LINE_MASK;
    wr(REG_LINE, lcfg, 4'hF, RESP_OKAY);
    for (int j = 0; j < 8; j++) begin
      isig <= 8'($random(seed));
      cyc(3);
      for (int i = 0; i < NUM_LINES; i++) begin
        chk(34'({tl_oe[i], tl_oe[i] & tl_out[i]}),
            34'({lcfg[4*i+3], lcfg[4*i+3] & isig[lcfg[4*i+:3]]}));
      end
    end
    wr(REG_LINE, 32'h0, 4'hF, RESP_OKAY);
    // function pin polarity and detection mode
    pol = 10'($random(seed));
    wr(REG_FUNC, {6'h0, pol, 16'h0}, 4'hF, RESP_OKAY);
    fpin <= 10'($random(seed));
    cyc(4);
    chk(34'(fcond), 34'(fpin ^ pol));
    wr(REG_FUNC, 32'h3FF, 4'hF, RESP_OKAY);
    cyc(4);
    chk(34'(fcond), 34'(0));
    fpin <= '0;
    cyc(4);
    base = n_fc;
    fpin <= 10'h001;
    cyc(4);
    chk(34'(n_fc - base), 34'(1));
    end_sim();
  end
endmodule
